// File: core/psr_pkg.sv
/*
  Constants shared by the power-state and reset sequencer: input indices of
  the synchroniser vector, reset values, sleep targets and timing counts.
  Assumes a single 125 MHz core clock.
*/
package psr_pkg;

  // ==========================================================================
  // Clock
  localparam int unsigned CLK_PERIOD_NS      = 8;

  // ==========================================================================
  // Timing
  // Length of the reset pulse started by one reset button press
  localparam int unsigned RESET_PULSE_NS     = 1000;
  localparam int unsigned RESET_PULSE_CYC    =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Warning time on the suspend-imminent output before a sleep state
  localparam int unsigned SUSPEND_WARN_NS    = 1000;
  localparam int unsigned SUSPEND_WARN_CYC   =
    (SUSPEND_WARN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_WIDTH          = 16;

  // ==========================================================================
  // Synchroniser vector layout
  localparam int unsigned IX_PWR_BTN         = 0;
  localparam int unsigned IX_RST_BTN         = 1;
  localparam int unsigned IX_PGOOD           = 2;
  localparam int unsigned IX_RAIL_LOW        = 3;
  localparam int unsigned IX_WAKE_PCIE       = 4;
  localparam int unsigned IX_WAKE_GEN        = 5;
  localparam int unsigned IX_BAT_LOW         = 6;
  localparam int unsigned IX_OVERTEMP        = 7;
  localparam int unsigned IX_ALERT           = 8;
  localparam int unsigned IX_LID             = 9;
  localparam int unsigned IX_SLEEP_BTN       = 10;
  localparam int unsigned NUM_SYNC           = 11;
  // Idle levels: everything high except the rail-low flag
  localparam logic [10:0] SYNC_RESET         = 11'h7F7;

  // ==========================================================================
  // Sleep targets requested by software
  localparam logic [1:0]  TGT_NONE           = 2'h0;
  localparam logic [1:0]  TGT_S3             = 2'h1;
  localparam logic [1:0]  TGT_S4             = 2'h2;
  localparam logic [1:0]  TGT_S5             = 2'h3;

  // ==========================================================================
  // Power states
  typedef enum logic [2:0] {
    PSR_ON,
    PSR_WARN,
    PSR_S3,
    PSR_S4,
    PSR_S5
  } psr_state_e;

endpackage

// File: core/psr_power_state_reset.sv
/*
  Power-state and reset sequencer: synchronises button and status pins,
  produces the carrier reset, suspend indicators, thermal trip and event
  pulses for the operating system.
  Assumes software and the watchdog sit on core_clk; all pins are async.
*/
`timescale 1ns/10ps

// Functional notes
// R1: Power button falling edge leaves soft-off
// R2: Carrier holds each button low 16 ms
// R3: Reset button edge starts pulse, never held
// R4: Carrier reset on any listed reset cause
// R5: Low power-good means power not good
// R6: Suspend-imminent asserted before entering suspend
// R7: RAM indicator low exactly while in S3
// R8: Carrier may invert RAM indicator for supply
// R9: Disk indicator low while in S4
// R10: Soft-off indicator mirrors disk indicator
// R11: Either wake input wakes the system
// R12: Low battery-low input reported as event
// R13: Low over-temperature input reported as condition
// R14: Thermal-trip output low after CPU shutdown
// R15: Bus alert gives interrupt or wake
// R16: Sleep and lid presses reported upward
// R17: All pins synchronised before any logic
module psr_power_state_reset
  import psr_pkg::*;
#(
  parameter int unsigned CNT_W       = CNT_WIDTH,
  parameter int unsigned RESET_CYC   = RESET_PULSE_CYC,
  parameter int unsigned WARN_CYC    = SUSPEND_WARN_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       power_button_n,
  input  wire logic       reset_button_n,
  input  wire logic       main_power_good,
  input  wire logic       main_supply_rail_low,
  input  wire logic       pcie_wake_n,
  input  wire logic       general_wake_n,
  input  wire logic       battery_low_n,
  input  wire logic       overtemp_in_n,
  input  wire logic       mgmt_bus_alert_n,
  input  wire logic       lid_n,
  input  wire logic       sleep_button_n,
  input  wire logic       watchdog_timeout,
  input  wire logic       sw_reset_req,
  input  wire logic       sw_sleep_req,
  input  wire logic [1:0] sw_sleep_target,
  input  wire logic       alert_to_wake,
  input  wire logic       cpu_thermal_trip,
  output logic            carrier_reset_out_n,
  output logic            suspend_imminent_n,
  output logic            suspend_ram_ind_n,
  output logic            suspend_disk_ind_n,
  output logic            soft_off_ind_n,
  output logic            thermal_shutdown_n,
  output logic [2:0]      power_state,
  output logic            wake_event,
  output logic            power_button_event,
  output logic            sleep_button_event,
  output logic            lid_event,
  output logic            battery_low_event,
  output logic            battery_low_active,
  output logic            overtemp_active,
  output logic            mgmt_interrupt
);

  // ==========================================================================
  // State
  typedef struct packed {
    psr_state_e            st;
    logic [1:0]            target;
    logic [NUM_SYNC-1:0]   meta;
    logic [NUM_SYNC-1:0]   sync;
    logic [NUM_SYNC-1:0]   prev;
    logic [CNT_W-1:0]      rst_cnt;
    logic [CNT_W-1:0]      warn_cnt;
    logic                  carrier_reset_out_n_n;
    logic                  susp_imm_n;
    logic                  ram_n;
    logic                  disk_n;
    logic                  thermal_n;
    logic                  wake_evt;
    logic                  pwr_evt;
    logic                  sleep_evt;
    logic                  lid_evt;
    logic                  bat_evt;
    logic                  bat_lvl;
    logic                  ot_lvl;
    logic                  smi;
  } psr_regs_s;

  psr_regs_s           r;
  psr_regs_s           next_r;
  logic [NUM_SYNC-1:0] pins;
  logic [NUM_SYNC-1:0] fall;
  logic                reset_req;
  logic                wake_any;

  assign pins = {sleep_button_n, lid_n, mgmt_bus_alert_n, overtemp_in_n, battery_low_n,
                 general_wake_n, pcie_wake_n, main_supply_rail_low, main_power_good,
                 reset_button_n, power_button_n};

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    // R17: two-stage synchroniser
    next_r.meta = pins;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
    fall = r.prev & ~r.sync;

    // R3: pulse per press, not level
    if (fall[IX_RST_BTN]) begin
      next_r.rst_cnt = CNT_W'(RESET_CYC);
    end else if (r.rst_cnt != '0) begin
      next_r.rst_cnt = r.rst_cnt - 1'b1;
    end

    // R4: reset causes, R5 included
    reset_req = (r.rst_cnt != '0) | ~r.sync[IX_PGOOD] | r.sync[IX_RAIL_LOW] |
                watchdog_timeout | sw_reset_req | (r.st != PSR_ON);
    next_r.carrier_reset_out_n_n = ~reset_req;

    // R11: wake sources, R15 and R16 wake paths
    wake_any = fall[IX_WAKE_PCIE] | fall[IX_WAKE_GEN] | fall[IX_SLEEP_BTN] |
               fall[IX_PWR_BTN] | (fall[IX_ALERT] & alert_to_wake);

    next_r.wake_evt = 1'b0;
    case (r.st)
      PSR_ON: begin
        // R6: warn before suspend
        if (sw_sleep_req && sw_sleep_target != TGT_NONE) begin
          next_r.target   = sw_sleep_target;
          next_r.warn_cnt = CNT_W'(WARN_CYC);
          next_r.st       = PSR_WARN;
        end
      end
      PSR_WARN: begin
        if (r.warn_cnt <= CNT_W'(1)) begin
          next_r.warn_cnt = '0;
          case (r.target)
            TGT_S3:  next_r.st = PSR_S3;
            TGT_S4:  next_r.st = PSR_S4;
            default: next_r.st = PSR_S5;
          endcase
        end else begin
          next_r.warn_cnt = r.warn_cnt - 1'b1;
        end
      end
      PSR_S3, PSR_S4: begin
        if (wake_any) begin
          next_r.st       = PSR_ON;
          next_r.wake_evt = 1'b1;
        end
      end
      PSR_S5: begin
        // R1: power button leaves soft-off
        if (fall[IX_PWR_BTN]) begin
          next_r.st       = PSR_ON;
          next_r.wake_evt = 1'b1;
        end
      end
      default: begin
        next_r.st = PSR_S5;
      end
    endcase

    // R14: trip forces off and latches low
    if (cpu_thermal_trip) begin
      next_r.st        = PSR_S5;
      next_r.wake_evt  = 1'b0;
      next_r.thermal_n = 1'b0;
    end

    // Indicators follow the state being entered, so they align with power_state
    next_r.susp_imm_n = (next_r.st == PSR_ON);
    // R7: RAM indicator
    next_r.ram_n      = (next_r.st != PSR_S3);
    // R9: disk indicator, low in S4 and soft-off
    next_r.disk_n     = ~((next_r.st == PSR_S4) || (next_r.st == PSR_S5));

    // R16: button and lid reports
    next_r.pwr_evt   = fall[IX_PWR_BTN] & (r.st == PSR_ON);
    next_r.sleep_evt = fall[IX_SLEEP_BTN] & (r.st == PSR_ON);
    next_r.lid_evt   = r.prev[IX_LID] ^ r.sync[IX_LID];
    // R12: battery low level and edge
    next_r.bat_evt   = fall[IX_BAT_LOW];
    next_r.bat_lvl   = ~r.sync[IX_BAT_LOW];
    // R13: off-module over-temperature
    next_r.ot_lvl    = ~r.sync[IX_OVERTEMP];
    // R15: alert routed to interrupt
    next_r.smi       = fall[IX_ALERT] & ~alert_to_wake;
  end

  // ==========================================================================
  // Registers
  // Reset leaves the system in soft-off with the carrier held in reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r            <= '0;
      r.st         <= PSR_S5;
      r.meta       <= SYNC_RESET;
      r.sync       <= SYNC_RESET;
      r.prev       <= SYNC_RESET;
      r.susp_imm_n <= 1'b0;
      r.ram_n      <= 1'b1;
      r.disk_n     <= 1'b0;
      r.thermal_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  assign carrier_reset_out_n = r.carrier_reset_out_n_n;
  assign suspend_imminent_n  = r.susp_imm_n;
  assign suspend_ram_ind_n   = r.ram_n;
  assign suspend_disk_ind_n  = r.disk_n;
  // R10: same flop as disk indicator
  assign soft_off_ind_n      = r.disk_n;
  assign thermal_shutdown_n  = r.thermal_n;
  assign power_state         = r.st;
  assign wake_event          = r.wake_evt;
  assign power_button_event  = r.pwr_evt;
  assign sleep_button_event  = r.sleep_evt;
  assign lid_event           = r.lid_evt;
  assign battery_low_event   = r.bat_evt;
  assign battery_low_active  = r.bat_lvl;
  assign overtemp_active     = r.ot_lvl;
  assign mgmt_interrupt      = r.smi;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_sleep_start;
    r.st == PSR_ON && sw_sleep_req && sw_sleep_target != TGT_NONE && !cpu_thermal_trip;
  endsequence

  sequence seq_warned;
    !suspend_imminent_n && r.st == PSR_WARN;
  endsequence

  power_button_wake_a: assert property ( // R1
    (r.st == PSR_S5 && fall[IX_PWR_BTN] && !cpu_thermal_trip) |=> (r.st == PSR_ON && wake_event))
    else $error("power button did not leave soft-off");

  reset_pulse_len_a: assert property ( // R3
    fall[IX_RST_BTN] |=> (r.rst_cnt == CNT_W'(RESET_CYC)))
    else $error("reset pulse not started at full length");

  reset_release_a: assert property ( // R3
    (r.st == PSR_ON && r.rst_cnt == '0 && !fall[IX_RST_BTN] && r.sync[IX_PGOOD] &&
     !r.sync[IX_RAIL_LOW] && !watchdog_timeout && !sw_reset_req) |=> carrier_reset_out_n)
    else $error("carrier reset held without cause");

  reset_cause_a: assert property ( // R4
    (watchdog_timeout || sw_reset_req || r.sync[IX_RAIL_LOW]) |=> !carrier_reset_out_n)
    else $error("carrier reset missing for reset cause");

  power_good_a: assert property ( // R5
    !r.sync[IX_PGOOD] |=> !carrier_reset_out_n)
    else $error("carrier reset missing with power not good");

  suspend_warn_a: assert property ( // R6
    seq_sleep_start |=> seq_warned)
    else $error("suspend warning not given");

  suspend_order_a: assert property ( // R6
    (r.st == PSR_S3 && $past(r.st) != PSR_S3) |-> ($past(r.st) == PSR_WARN && !$past(r.susp_imm_n)))
    else $error("S3 entered without warning");

  ram_indicator_a: assert property ( // R7
    suspend_ram_ind_n == (power_state != PSR_S3))
    else $error("RAM indicator disagrees with state");

  disk_indicator_a: assert property ( // R9
    (power_state == PSR_S4) |-> !suspend_disk_ind_n)
    else $error("disk indicator high in S4");

  soft_off_tie_a: assert property ( // R10
    soft_off_ind_n == suspend_disk_ind_n)
    else $error("soft-off indicator differs from disk indicator");

  wake_inputs_a: assert property ( // R11
    ((r.st == PSR_S3 || r.st == PSR_S4) && (fall[IX_WAKE_PCIE] || fall[IX_WAKE_GEN]) &&
     !cpu_thermal_trip) |=> r.st == PSR_ON)
    else $error("wake input ignored");

  battery_low_a: assert property ( // R12
    !r.sync[IX_BAT_LOW] |=> battery_low_active)
    else $error("battery low not reported");

  overtemp_a: assert property ( // R13
    $fell(r.sync[IX_OVERTEMP]) |=> overtemp_active)
    else $error("over-temperature not reported");

  thermal_trip_a: assert property ( // R14
    cpu_thermal_trip |=> (!thermal_shutdown_n && power_state == PSR_S5))
    else $error("thermal trip output not asserted");

  alert_route_a: assert property ( // R15
    fall[IX_ALERT] |=> (mgmt_interrupt != $past(alert_to_wake)))
    else $error("bus alert routed wrongly");

  sleep_report_a: assert property ( // R16
    (fall[IX_SLEEP_BTN] && r.st == PSR_ON) |=> sleep_button_event ##1 !sleep_button_event)
    else $error("sleep button press not reported once");

  sync_chain_a: assert property ( // R17
    ##1 r.prev == $past(r.sync))
    else $error("synchroniser chain broken");

endmodule

// File: verification/psr_carrier_model.sv
/*
  Carrier model: buttons, sensors and main supply feeding the sequencer.
  Assumes core_clk comes from the bench; pins move on its falling edge.
*/
`timescale 1ns/10ps

module psr_carrier_model (
  input  wire logic       core_clk,
  input  wire logic       suspend_ram_ind_n,
  output logic      [8:0] pin_n,
  output logic            main_power_good,
  output logic            main_supply_rail_low,
  output logic            supply_on_n
);
  // ========================================
  // Supply switch
  // inverted RAM indicator switches main rails
  assign supply_on_n = ~suspend_ram_ind_n;

  // ========================================
  // Idle levels
  // supply starts with power good
  initial begin
    pin_n                = 9'h1FF;
    main_power_good      = 1'b1;
    main_supply_rail_low = 1'b0;
  end

  // ========================================
  // Press: pull one line low, the pull-up restores it after
  // hold scaled down, 16 ms would swamp the run
  task automatic press(input int idx, input int hold);
    @(negedge core_clk);
    pin_n[idx] = 1'b0;
    repeat (hold) @(negedge core_clk);
    pin_n[idx] = 1'b1;
  endtask

  // supply drops power-good or the rail sags
  task automatic supply_fault(input logic pg, input logic low);
    @(negedge core_clk);
    main_power_good      = pg;
    main_supply_rail_low = low;
  endtask
endmodule

// File: verification/tb_psr_power_state_reset.sv
/*
  Self-checking bench for the power-state and reset sequencer.
  Assumes the carrier model is compiled first; pulse counts are shortened.
*/
`timescale 1ns/10ps

module tb_psr_power_state_reset;
  import psr_pkg::*;
  localparam int RCYC = 4;
  localparam int WCYC = 4;
  logic       core_clk, rst, watchdog_timeout, sw_reset_req, sw_sleep_req;
  logic       alert_to_wake, cpu_thermal_trip, main_power_good, main_supply_rail_low;
  logic       supply_on_n;
  logic [1:0] sw_sleep_target;
  logic [8:0] pin_n;
  logic       carrier_reset_out_n, suspend_imminent_n, suspend_ram_ind_n;
  logic       suspend_disk_ind_n, soft_off_ind_n, thermal_shutdown_n;
  logic [2:0] power_state;
  logic       wake_event, power_button_event, sleep_button_event, lid_event;
  logic       battery_low_event, battery_low_active, overtemp_active, mgmt_interrupt;
  logic [5:0] ev;
  logic [5:0] exp_q[$];
  int         errors, tests_run, seed, i, t, tg;
  int         pidx[6] = '{0, 8, 7, 4, 6, 5};
  logic [5:0] evx[6]  = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
  int         wk[5]   = '{0, 2, 3, 0, 6};

  psr_power_state_reset #(.RESET_CYC(RCYC), .WARN_CYC(WCYC)) psr_power_state_reset_inst (
    .core_clk, .rst, .power_button_n(pin_n[0]), .reset_button_n(pin_n[1]),
    .main_power_good, .main_supply_rail_low, .pcie_wake_n(pin_n[2]),
    .general_wake_n(pin_n[3]), .battery_low_n(pin_n[4]), .overtemp_in_n(pin_n[5]),
    .mgmt_bus_alert_n(pin_n[6]), .lid_n(pin_n[7]), .sleep_button_n(pin_n[8]),
    .watchdog_timeout, .sw_reset_req, .sw_sleep_req, .sw_sleep_target, .alert_to_wake,
    .cpu_thermal_trip, .carrier_reset_out_n, .suspend_imminent_n, .suspend_ram_ind_n,
    .suspend_disk_ind_n, .soft_off_ind_n, .thermal_shutdown_n, .power_state,
    .wake_event, .power_button_event, .sleep_button_event, .lid_event,
    .battery_low_event, .battery_low_active, .overtemp_active, .mgmt_interrupt);

  psr_carrier_model psr_carrier_model_inst (
    .core_clk, .suspend_ram_ind_n, .pin_n, .main_power_good, .main_supply_rail_low,
    .supply_on_n);

  // ========================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    close_out();
  end

  // ========================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv) begin
      errors++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait; a stuck state ends the run
  task automatic wait_state(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (power_state !== s && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check("power_state", 8'(power_state), 8'(s));
    if (power_state !== s) close_out();
  endtask

  task automatic set_cause(input int k, input logic on);
    if (k == 0) psr_carrier_model_inst.supply_fault(!on, 1'b0);
    else if (k == 1) psr_carrier_model_inst.supply_fault(1'b1, on);
    else if (k == 2) watchdog_timeout = on;
    else sw_reset_req = on;
  endtask

  // ========================================
  // Event monitor: every pulse must match the oldest note
  assign ev = {wake_event, power_button_event, sleep_button_event, lid_event,
               battery_low_event, mgmt_interrupt};
  always @(negedge core_clk) begin
    if (!rst && ev !== 6'h00) begin
      if (exp_q.size() == 0) check("event", 8'(ev), 8'h00);
      else check("event", 8'(ev), 8'(exp_q.pop_front()));
    end
  end

  // ========================================
  // Main sequence
  initial begin
    seed = 32'hbc2b;
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    watchdog_timeout = 1'b0;
    sw_reset_req = 1'b0;
    sw_sleep_req = 1'b0;
    sw_sleep_target = TGT_NONE;
    alert_to_wake = 1'b0;
    cpu_thermal_trip = 1'b0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    check("soft_off", soft_off_ind_n, 1'b0);
    check("thermal_shutdown_n", thermal_shutdown_n, 1'b1);
    exp_q.push_back(6'h20);
    psr_carrier_model_inst.press(0, 4);
    wait_state(PSR_ON, 20);
    repeat (3) @(negedge core_clk);
    check("reset_out", carrier_reset_out_n, 1'b1);
    $display("test power-up done");
    // Pulse must end while the button is still held
    fork
      psr_carrier_model_inst.press(1, 20);
      begin
        repeat (6) @(negedge core_clk);
        check("reset_out", carrier_reset_out_n, 1'b0);
        repeat (RCYC + 4) @(negedge core_clk);
        check("reset_out", carrier_reset_out_n, 1'b1);
      end
    join
    for (i = 0; i < 4; i++) begin
      set_cause(i, 1'b1);
      repeat (5) @(negedge core_clk);
      check("reset_out", carrier_reset_out_n, 1'b0);
      set_cause(i, 1'b0);
      repeat (6) @(negedge core_clk);
      check("reset_out", carrier_reset_out_n, 1'b1);
    end
    $display("test reset causes done");
    for (i = 0; i < 6; i++) begin
      if (evx[i] != 6'h00) exp_q.push_back(evx[i]);
      if (pidx[i] == 7) exp_q.push_back(6'h04);
      fork
        psr_carrier_model_inst.press(pidx[i], 5 + {$random(seed)} % 4);
        begin
          repeat (5) @(negedge core_clk);
          check("bat_low", battery_low_active, pidx[i] == 4);
          check("overtemp", overtemp_active, pidx[i] == 5);
        end
      join
      repeat (3 + {$random(seed)} % 6) @(negedge core_clk);
    end
    $display("test events done");
    for (t = 1; t < 5; t++) begin
      tg = (t == 4) ? 1 : t;
      alert_to_wake = (t == 4);
      @(negedge core_clk);
      sw_sleep_req = 1'b1;
      sw_sleep_target = 2'(tg);
      @(negedge core_clk);
      sw_sleep_req = 1'b0;
      @(negedge core_clk);
      check("imminent", suspend_imminent_n, 1'b0);
      check("ram_ind", suspend_ram_ind_n, 1'b1);
      wait_state(3'(tg + 1), WCYC + 10);
      check("ram_ind", suspend_ram_ind_n, tg != 1);
      check("disk_ind", suspend_disk_ind_n, tg == 1);
      check("soft_off", soft_off_ind_n, tg == 1);
      check("supply_on", supply_on_n, tg == 1);
      repeat ({$random(seed)} % 8) @(negedge core_clk);
      exp_q.push_back(6'h20);
      psr_carrier_model_inst.press(wk[t], 4);
      wait_state(PSR_ON, 20);
      check("ram_ind", suspend_ram_ind_n, 1'b1);
      check("imminent", suspend_imminent_n, 1'b1);
    end
    $display("test sleep and wake done");
    @(negedge core_clk);
    sw_sleep_req = 1'b1;
    sw_sleep_target = TGT_NONE;
    @(negedge core_clk);
    sw_sleep_req = 1'b0;
    repeat (2) @(negedge core_clk);
    check("state", 8'(power_state), 8'(PSR_ON));
    check("imminent", suspend_imminent_n, 1'b1);
    @(negedge core_clk);
    cpu_thermal_trip = 1'b1;
    @(negedge core_clk);
    cpu_thermal_trip = 1'b0;
    wait_state(PSR_S5, 10);
    check("thermal_shutdown_n", thermal_shutdown_n, 1'b0);
    psr_carrier_model_inst.press(2, 4);
    repeat (6) @(negedge core_clk);
    check("state", 8'(power_state), 8'(PSR_S5));
    check("thermal_shutdown_n", thermal_shutdown_n, 1'b0);
    check("queue", 8'(exp_q.size()), 8'h00);
    $display("test thermal done");
    close_out();
  end
endmodule
